// >>> hdl/mem_addr_defs.svh
`ifndef MEM_ADDR_DEFS_SVH
`define MEM_ADDR_DEFS_SVH
// Program memory
`define PMEM_DEPTH_LARGE 4096
`define PMEM_DEPTH_SMALL 2048
`define PMEM_ADDR_MSB 11
`define CONV_BASE_HI 7'h7f
// Data memory map
`define DMEM_DEPTH 256
`define SPW_ADDR 8'hff
`define STACK_BASE_HI 2'h3
`define TP_ADDR_LOW 8'hfc
`define TP_ADDR_MID 8'hfd
`define TP_ADDR_HIGH 8'hfe
`define SP_INIT_LOC 4'hc
`define SP_FORBIDDEN 4'hf
`endif

// >>> hdl/mem_addr_pkg.sv
package mem_addr_pkg;
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_TAB_LO = 3'b001,
		OP_TAB_HI = 3'b010,
		OP_CONV = 3'b011,
		OP_CALL = 3'b100,
		OP_INT = 3'b101,
		OP_RET = 3'b110,
		OP_INTERRUPT_RETURN = 3'b111
	} stack_op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PUSH = 3'b001,
		ST_POP_SP = 3'b010,
		ST_POP = 3'b011,
		ST_DONE = 3'b100
	} seq_state_t;
endpackage

// >>> hdl/prog_mem.sv
`timescale 1ns/10ps
`include "mem_addr_defs.svh"
// Program store; the small variant folds the upper half onto the lower
module prog_mem
#(
	parameter bit SMALL = 1'b0
)
(
	input wire logic mclk_in,
	input wire logic we_in,
	input wire logic [11:0] waddr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [11:0] raddr_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem_q [0:`PMEM_DEPTH_LARGE-1];
	logic [11:0] ra;
	logic [11:0] wa;
	always_comb
	begin
		ra = raddr_in;
		wa = waddr_in;
		if (SMALL)
		begin
			ra[`PMEM_ADDR_MSB] = 1'b0; // [RULE_08]
			wa[`PMEM_ADDR_MSB] = 1'b0;
		end
	end
	// Loaded by the mask port; no reset since contents are program data
	always_ff @(posedge mclk_in)
	begin
		if (we_in)
		begin
			mem_q[wa] <= wdata_in; // [RULE_07]
		end
	end
	assign rdata_out = mem_q[ra];
endmodule

// >>> hdl/data_mem.sv
`timescale 1ns/10ps
`include "mem_addr_defs.svh"
// 256 x 4 data memory, one write port, two read ports
module data_mem
(
	input wire logic mclk_in,
	input wire logic we_in,
	input wire logic [7:0] waddr_in,
	input wire logic [3:0] wdata_in,
	input wire logic [7:0] raddr_a_in,
	output logic [3:0] rdata_a_out,
	input wire logic [7:0] raddr_b_in,
	output logic [3:0] rdata_b_out
);
	// Not reset: the stack pointer word must survive reset
	logic [3:0] mem_q [0:`DMEM_DEPTH-1]; // [RULE_19]
	always_ff @(posedge mclk_in)
	begin
		if (we_in)
		begin
			mem_q[waddr_in] <= wdata_in;
		end
	end
	assign rdata_a_out = mem_q[raddr_a_in];
	assign rdata_b_out = mem_q[raddr_b_in];
endmodule

// >>> hdl/mem_addr_stack.sv
`timescale 1ns/10ps
`include "mem_addr_defs.svh"
//Operation
//[RULE_01] Next instruction byte is fetched at the program counter address.
//[RULE_02] Table reads load low or high nibble; high read post-increments.
//[RULE_03] Table pointer is 12 bits, reaching all program memory.
//[RULE_04] Conversion output sends upper nibble high port, lower nibble low.
//[RULE_05] Conversion table is last 32 bytes; offset from carry and data.
//[RULE_06] Carry is offset MSB; clear carry selects first 16 entries.
//[RULE_07] Program memory 2048 or 4096 bytes, from address zero.
//[RULE_08] Small variant ignores address bit 11.
//[RULE_09] Pointer pair: high selects page, low selects word.
//[RULE_10] Low pointer post-increments or post-decrements after access.
//[RULE_11] Low register indexes one port output pin bit.
//[RULE_12] Zero page uses words 00h-0Fh from operand low nibble.
//[RULE_13] Call pushes PC; interrupt also flags; returns pop matching.
//[RULE_14] Fifteen stack locations in C0h-FBh, four words each.
//[RULE_15] Location n starts at C0h plus four times n.
//[RULE_16] Pointer names next save; decrement after save, increment first.
//[RULE_17] Stack pointer lives in data word FFh.
//[RULE_18] Software never writes 15 to the stack pointer.
//[RULE_19] Reset leaves stack pointer alone; software initialises it.
//[RULE_20] No overflow check; pushes overwrite whatever is there.
//[RULE_21] Locations 13, 14 overlap timer count registers.
//[RULE_22] Table pointer is mapped into data memory as nibbles.
//[RULE_23] Table pointer increment wraps modulo 4096.
module mem_addr_stack
	import mem_addr_pkg::*;
#(
	parameter bit SMALL = 1'b0
)
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [11:0] program_counter_in,
	output logic [7:0] fetch_byte_out,
	input wire logic pm_we_in,
	input wire logic [11:0] pm_waddr_in,
	input wire logic [7:0] pm_wdata_in,
	input wire logic [2:0] op_in,
	input wire logic op_valid_in,
	input wire logic carry_flag_in,
	input wire logic [3:0] flags_in,
	output logic busy_out,
	output logic [3:0] acc_load_out,
	output logic acc_load_valid_out,
	output logic [3:0] low_output_port_out,
	output logic [3:0] high_output_port_out,
	output logic port_load_out,
	output logic [11:0] ret_pc_out,
	output logic [3:0] ret_flags_out,
	output logic ret_valid_out,
	input wire logic [3:0] hi_reg_in,
	input wire logic [3:0] lo_reg_in,
	input wire logic lo_inc_in,
	input wire logic lo_dec_in,
	input wire logic lo_load_in,
	output logic [3:0] lo_reg_out,
	output logic [3:0] hi_reg_out,
	output logic [2:0] pin_port_out,
	output logic [1:0] pin_bit_out,
	input wire logic zp_mode_in,
	input wire logic [7:0] operand_in,
	input wire logic dm_we_in,
	input wire logic [3:0] dm_wdata_in,
	output logic [3:0] dm_rdata_out,
	output logic [3:0] stack_location_pointer_out,
	output logic [11:0] table_pointer_out
);
	seq_state_t state_q;
	stack_op_t op_q;
	logic [1:0] word_q;
	logic [3:0] loc_q;
	logic [11:0] ret_pc_q;
	logic [3:0] ret_flags_q;
	logic [11:0] pm_raddr;
	logic [7:0] pm_rdata;
	logic [7:0] fetch_q;
	logic [11:0] tp;
	logic [7:0] dm_addr;
	logic [7:0] st_addr;
	logic [3:0] dm_rd;
	logic [3:0] sp_rd;
	logic [3:0] st_rd;
	logic dm_we;
	logic [7:0] dm_wa;
	logic [3:0] dm_wd;
	logic [3:0] lo_q;
	logic [3:0] hi_q;
	logic [3:0] acc_q;
	logic acc_v_q;
	logic [3:0] lo_port_q;
	logic [3:0] hi_port_q;
	logic port_v_q;
	logic ret_v_q;
	logic [4:0] conv_off;
	logic [6:0] conv_hi;
	logic [11:0] tp_q;
	logic [11:0] tp_inc;
	logic tp_wr;

	////////////////////////////////////////////////////////////////////
	// Memories
	prog_mem #(.SMALL(SMALL)) u_pm (
		.mclk_in(mclk_in),
		.we_in(pm_we_in),
		.waddr_in(pm_waddr_in),
		.wdata_in(pm_wdata_in),
		.raddr_in(pm_raddr),
		.rdata_out(pm_rdata)
	);
	// Shared port A serves data access and stack, port B the pointer word
	data_mem u_dm (
		.mclk_in(mclk_in),
		.we_in(dm_we),
		.waddr_in(dm_wa),
		.wdata_in(dm_wd),
		.raddr_a_in(st_addr),
		.rdata_a_out(st_rd),
		.raddr_b_in(`SPW_ADDR),
		.rdata_b_out(sp_rd)
	);

	////////////////////////////////////////////////////////////////////
	// Program memory address selection
	assign tp = tp_q; // [RULE_03]
	assign tp_inc = tp + 12'h001; // [RULE_23]
	assign conv_off = {carry_flag_in, dm_rd}; // [RULE_05] [RULE_06]
	assign conv_hi = SMALL ? {1'b0, 6'h3f} : `CONV_BASE_HI;
	always_comb
	begin
		pm_raddr = program_counter_in; // [RULE_01]
		if (op_valid_in && state_q == ST_IDLE)
		begin
			case (op_in)
				OP_TAB_LO: pm_raddr = tp; // [RULE_02]
				OP_TAB_HI: pm_raddr = tp;
				OP_CONV: pm_raddr = {conv_hi, conv_off}; // [RULE_05]
				default: pm_raddr = program_counter_in;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data memory addressing
	always_comb
	begin
		if (zp_mode_in)
		begin
			dm_addr = {4'h0, operand_in[3:0]}; // [RULE_12]
		end
		else
		begin
			dm_addr = {hi_q, lo_q}; // [RULE_09]
		end
	end
	// Stack word address: C0h + 4*loc + word
	assign st_addr = (state_q == ST_IDLE) ? dm_addr
		: {`STACK_BASE_HI, loc_q, word_q}; // [RULE_14] [RULE_15]
	// Table pointer words read from the pointer itself, never stale
	always_comb
	begin
		case (st_addr)
			`TP_ADDR_LOW: dm_rd = tp_q[3:0]; // [RULE_22]
			`TP_ADDR_MID: dm_rd = tp_q[7:4];
			`TP_ADDR_HIGH: dm_rd = tp_q[11:8];
			default: dm_rd = st_rd;
		endcase
	end
	assign dm_rdata_out = dm_rd;
	assign stack_location_pointer_out = sp_rd; // [RULE_17]
	assign table_pointer_out = tp;

	////////////////////////////////////////////////////////////////////
	// Data memory write mux; pushes are not range checked
	always_comb
	begin
		dm_we = 1'b0;
		dm_wa = dm_addr;
		dm_wd = dm_wdata_in;
		if (state_q == ST_PUSH)
		begin
			dm_we = 1'b1; // [RULE_20] [RULE_21]
			dm_wa = st_addr;
			case (word_q)
				2'd0: dm_wd = ret_pc_q[3:0];
				2'd1: dm_wd = ret_pc_q[7:4];
				2'd2: dm_wd = ret_pc_q[11:8];
				default: dm_wd = (op_q == OP_INT) ? flags_in : st_rd;
			endcase
		end
		else if (state_q == ST_DONE && op_q inside {OP_CALL, OP_INT})
		begin
			dm_we = 1'b1;
			dm_wa = `SPW_ADDR;
			dm_wd = loc_q - 4'h1; // [RULE_16]
		end
		else if (state_q == ST_POP_SP)
		begin
			dm_we = 1'b1;
			dm_wa = `SPW_ADDR;
			dm_wd = loc_q;
		end
		else if (state_q == ST_IDLE && dm_we_in)
		begin
			dm_we = 1'b1;
		end
	end

	// One 12-bit register so the increment carries across all nibbles
	assign tp_wr = op_valid_in && state_q == ST_IDLE && op_in == OP_TAB_HI;
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			tp_q <= 12'h000;
		end
		else if (dm_we && dm_wa == `TP_ADDR_LOW)
		begin
			tp_q[3:0] <= dm_wd; // [RULE_22]
		end
		else if (dm_we && dm_wa == `TP_ADDR_MID)
		begin
			tp_q[7:4] <= dm_wd; // [RULE_22]
		end
		else if (dm_we && dm_wa == `TP_ADDR_HIGH)
		begin
			tp_q[11:8] <= dm_wd; // [RULE_22]
		end
		else if (tp_wr)
		begin
			tp_q <= tp_inc; // [RULE_23]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Stack sequencer
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_q <= ST_IDLE;
			op_q <= OP_NONE;
			word_q <= 2'd0;
			loc_q <= 4'h0;
			ret_pc_q <= 12'h000;
			ret_flags_q <= 4'h0;
			ret_v_q <= 1'b0;
		end
		else
		begin
			ret_v_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					word_q <= 2'd0;
					if (op_valid_in && op_in inside {OP_CALL, OP_INT})
					begin
						op_q <= stack_op_t'(op_in);
						loc_q <= sp_rd; // [RULE_16]
						ret_pc_q <= program_counter_in;
						state_q <= ST_PUSH; // [RULE_13]
					end
					else if (op_valid_in && op_in inside {OP_RET, OP_INTERRUPT_RETURN})
					begin
						op_q <= stack_op_t'(op_in);
						loc_q <= sp_rd + 4'h1; // [RULE_16]
						state_q <= ST_POP_SP;
					end
				end
				ST_PUSH:
				begin
					word_q <= word_q + 2'd1;
					if (word_q == 2'd3)
					begin
						state_q <= ST_DONE;
					end
				end
				ST_POP_SP:
				begin
					state_q <= ST_POP;
				end
				ST_POP:
				begin
					word_q <= word_q + 2'd1;
					case (word_q)
						2'd0: ret_pc_q[3:0] <= st_rd;
						2'd1: ret_pc_q[7:4] <= st_rd;
						2'd2: ret_pc_q[11:8] <= st_rd;
						default: ret_flags_q <= st_rd; // [RULE_13]
					endcase
					if (word_q == 2'd3)
					begin
						state_q <= ST_DONE;
						ret_v_q <= 1'b1;
					end
				end
				ST_DONE:
				begin
					state_q <= ST_IDLE;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
	assign busy_out = (state_q != ST_IDLE);
	assign ret_pc_out = ret_pc_q;
	assign ret_flags_out = (op_q == OP_INTERRUPT_RETURN) ? ret_flags_q : 4'h0;
	assign ret_valid_out = ret_v_q;

	////////////////////////////////////////////////////////////////////
	// Table and conversion results
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			acc_q <= 4'h0;
			acc_v_q <= 1'b0;
			lo_port_q <= 4'h0;
			hi_port_q <= 4'h0;
			port_v_q <= 1'b0;
			fetch_q <= 8'h00;
		end
		else
		begin
			acc_v_q <= 1'b0;
			port_v_q <= 1'b0;
			fetch_q <= pm_rdata; // [RULE_01]
			if (op_valid_in && state_q == ST_IDLE)
			begin
				if (op_in == OP_TAB_LO)
				begin
					acc_q <= pm_rdata[3:0]; // [RULE_02]
					acc_v_q <= 1'b1;
				end
				else if (op_in == OP_TAB_HI)
				begin
					acc_q <= pm_rdata[7:4]; // [RULE_02]
					acc_v_q <= 1'b1;
				end
				else if (op_in == OP_CONV)
				begin
					hi_port_q <= pm_rdata[7:4]; // [RULE_04]
					lo_port_q <= pm_rdata[3:0];
					port_v_q <= 1'b1;
				end
			end
		end
	end
	assign fetch_byte_out = fetch_q;
	assign acc_load_out = acc_q;
	assign acc_load_valid_out = acc_v_q;
	assign low_output_port_out = lo_port_q;
	assign high_output_port_out = hi_port_q;
	assign port_load_out = port_v_q;

	////////////////////////////////////////////////////////////////////
	// Pointer pair with post increment and decrement
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			lo_q <= 4'h0;
			hi_q <= 4'h0;
		end
		else if (lo_load_in)
		begin
			lo_q <= lo_reg_in;
			hi_q <= hi_reg_in;
		end
		else if (lo_inc_in)
		begin
			lo_q <= lo_q + 4'h1; // [RULE_10]
		end
		else if (lo_dec_in)
		begin
			lo_q <= lo_q - 4'h1; // [RULE_10]
		end
	end
	assign lo_reg_out = lo_q;
	assign hi_reg_out = hi_q;
	// Pin index: 1101b gives port 7 bit 1, i.e. port 4 plus index/4
	assign pin_port_out = 3'd4 + {1'b0, lo_q[3:2]} - 3'd0; // [RULE_11]
	assign pin_bit_out = lo_q[1:0] ^ 2'b00; // [RULE_11]

	a_pop_pointer: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(state_q == ST_IDLE && op_valid_in && op_in == OP_RET)
		|=> loc_q == $past(sp_rd) + 4'h1) // [RULE_16]
		else $error("restore pointer not pre-incremented");
	a_conv_port: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(state_q == ST_IDLE && op_valid_in && op_in == OP_CONV)
		|=> port_v_q && hi_port_q == $past(pm_rdata[7:4])) // [RULE_04]
		else $error("conversion high nibble wrong");
	a_push_start: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(state_q == ST_IDLE && op_valid_in && op_in == OP_CALL)
		|=> state_q == ST_PUSH && word_q == 2'd0) // [RULE_13]
		else $error("call did not start a save");
	a_tab_wrap: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(state_q == ST_IDLE && op_valid_in && op_in == OP_TAB_HI
		&& !dm_we_in)
		|=> tp_q == $past(tp) + 12'h001) // [RULE_23]
		else $error("table pointer not incremented");
	a_tab_low: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(state_q == ST_IDLE && op_valid_in && op_in == OP_TAB_LO)
		|=> acc_v_q && acc_q == $past(pm_rdata[3:0])) // [RULE_02]
		else $error("table low nibble wrong");
	a_stack_addr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		state_q == ST_PUSH
		|-> dm_wa == 8'hc0 + {2'b00, loc_q, 2'b00} + {6'h00, word_q})
		else $error("stack word address wrong"); // [RULE_15]
endmodule

// >>> dv/cpu_seq_model.sv
`timescale 1ns/10ps
// Sequencer stand-in: hands one op to the block when it is idle
module cpu_seq_model
	import mem_addr_pkg::*;
(
	input wire logic mclk_in,
	input wire logic busy_in,
	output stack_op_t op_out,
	output logic op_valid_out
);
	initial
	begin
		op_out = OP_NONE;
		op_valid_out = 1'b0;
	end
	// Waits up to 20 cycles for idle: a request still busy after that is dropped
	task issue(input stack_op_t op, output bit ok);
		int i;
		ok = 1'b0;
		for (i = 0; i < 20 && !ok; i++)
		begin
			if (busy_in === 1'b0)
				ok = 1'b1;
			else
			begin
				@(posedge mclk_in);
				#1;
			end
		end
		op_out = op;
		op_valid_out = ok;
		@(posedge mclk_in);
		#1;
		op_valid_out = 1'b0;
		op_out = OP_NONE;
	endtask
endmodule

// >>> dv/mem_addr_stack_test.sv
`timescale 1ns/10ps
module mem_addr_stack_test;
	import mem_addr_pkg::*;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [11:0] program_counter_in = 12'h000;
	logic pm_we_in = 1'b0;
	logic [11:0] pm_waddr_in = 12'h000;
	logic [7:0] pm_wdata_in = 8'h00;
	logic carry_flag_in = 1'b0;
	logic [3:0] flags_in = 4'h0;
	logic [3:0] hi_reg_in = 4'h0;
	logic [3:0] lo_reg_in = 4'h0;
	logic lo_inc_in = 1'b0;
	logic lo_dec_in = 1'b0;
	logic lo_load_in = 1'b0;
	logic zp_mode_in = 1'b0;
	logic [7:0] operand_in = 8'h00;
	logic dm_we_in = 1'b0;
	logic [3:0] dm_wdata_in = 4'h0;
	logic [2:0] op_in;
	logic op_valid_in, busy_out, acc_load_valid_out, port_load_out;
	logic ret_valid_out;
	logic [7:0] fetch_byte_out;
	logic [3:0] acc_load_out, low_output_port_out, high_output_port_out;
	logic [3:0] ret_flags_out, lo_reg_out, hi_reg_out, dm_rdata_out;
	logic [3:0] stack_location_pointer_out;
	logic [11:0] ret_pc_out, table_pointer_out;
	logic [2:0] pin_port_out;
	logic [1:0] pin_bit_out;
	int num_errors = 0;
	int compares = 0;

	// Small variant, so the address fold can be seen
	mem_addr_stack #(.SMALL(1'b1)) u_dut (.mclk_in, .rstn_in,
		.program_counter_in, .fetch_byte_out, .pm_we_in, .pm_waddr_in,
		.pm_wdata_in, .op_in, .op_valid_in, .carry_flag_in, .flags_in,
		.busy_out, .acc_load_out, .acc_load_valid_out,
		.low_output_port_out, .high_output_port_out, .port_load_out,
		.ret_pc_out, .ret_flags_out, .ret_valid_out, .hi_reg_in,
		.lo_reg_in, .lo_inc_in, .lo_dec_in, .lo_load_in, .lo_reg_out,
		.hi_reg_out, .pin_port_out, .pin_bit_out, .zp_mode_in,
		.operand_in, .dm_we_in, .dm_wdata_in, .dm_rdata_out,
		.stack_location_pointer_out, .table_pointer_out);
	cpu_seq_model u_cpu (.mclk_in, .busy_in(busy_out), .op_out(op_in),
		.op_valid_out(op_valid_in));

	always #5 mclk_in = ~mclk_in;

	////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task tick;
		@(posedge mclk_in);
		#1;
	endtask
	task fail(input string m);
		$display("unexpected at %0t: %s", $time, m);
		num_errors++;
	endtask
	task chk4(input logic [3:0] g, input logic [3:0] e);
		compares++;
		if (g !== e)
			fail("nibble differs");
	endtask
	task chk12(input logic [11:0] g, input logic [11:0] e);
		compares++;
		if (g !== e)
			fail("address or byte differs");
	endtask
	// Bounded wait; a stuck handshake ends the run
	task wait_for(input int w);
		int i;
		bit hit;
		hit = 1'b0;
		for (i = 0; i < 20 && !hit; i++)
		begin
			case (w)
				0: hit = (acc_load_valid_out === 1'b1);
				1: hit = (port_load_out === 1'b1);
				2: hit = (ret_valid_out === 1'b1);
				default: hit = (busy_out === 1'b0);
			endcase
			if (!hit)
				tick;
		end
		if (!hit)
		begin
			fail("wait ran out");
			report_and_stop;
		end
	endtask
	task run_op(input stack_op_t op, input int w);
		bit ok;
		u_cpu.issue(op, ok);
		if (!ok)
			fail("block stayed busy");
		wait_for(w);
	endtask
	task set_ptr(input logic [7:0] a);
		hi_reg_in = a[7:4];
		lo_reg_in = a[3:0];
		lo_load_in = 1'b1;
		tick;
		lo_load_in = 1'b0;
	endtask
	task dm_st(input logic [3:0] d, input logic inc, input logic dec);
		dm_wdata_in = d;
		dm_we_in = 1'b1;
		lo_inc_in = inc;
		lo_dec_in = dec;
		tick;
		dm_we_in = 1'b0;
		lo_inc_in = 1'b0;
		lo_dec_in = 1'b0;
	endtask
	task dm_wr(input logic [7:0] a, input logic [3:0] d);
		set_ptr(a);
		dm_st(d, 1'b0, 1'b0);
	endtask
	task dm_chk(input logic [7:0] a, input logic [3:0] e);
		set_ptr(a);
		chk4(dm_rdata_out, e);
	endtask
	task pm_wr(input logic [11:0] a, input logic [7:0] d);
		pm_waddr_in = a;
		pm_wdata_in = d;
		pm_we_in = 1'b1;
		tick;
		pm_we_in = 1'b0;
	endtask
	task fetch_chk(input logic [11:0] a, input logic [7:0] e);
		program_counter_in = a;
		tick;
		tick;
		chk12({4'h0, fetch_byte_out}, {4'h0, e});
	endtask
	task conv(input logic c, input logic [3:0] d, input logic [7:0] e);
		dm_wr(8'h2f, d);
		carry_flag_in = c;
		run_op(OP_CONV, 1);
		chk4(high_output_port_out, e[7:4]);
		chk4(low_output_port_out, e[3:0]);
	endtask
	// Word 3 is preset so a call that wrongly saves flags shows up
	task push(input stack_op_t op, input logic [3:0] loc,
		input logic [11:0] pc, input logic [3:0] fl);
		logic [7:0] b;
		b = 8'hc0 + {2'h0, loc, 2'h0};
		dm_wr(b + 8'h03, 4'h9);
		dm_wr(8'hff, loc);
		program_counter_in = pc;
		flags_in = fl;
		run_op(op, 3);
		chk4(stack_location_pointer_out, loc - 4'h1);
		dm_chk(b, pc[3:0]);
		dm_chk(b + 8'h01, pc[7:4]);
		dm_chk(b + 8'h02, pc[11:8]);
		dm_chk(b + 8'h03, (op == OP_INT) ? fl : 4'h9);
	endtask
	task pop(input stack_op_t op, input logic [3:0] loc,
		input logic [11:0] pc, input logic [3:0] fl);
		run_op(op, 2);
		chk12(ret_pc_out, pc);
		if (op == OP_INTERRUPT_RETURN)
			chk4(ret_flags_out, fl);
		wait_for(3);
		chk4(stack_location_pointer_out, loc + 4'h1);
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) tick;
		rstn_in = 1'b1;
		tick;
		dm_wr(8'hff, 4'hc);
		pm_wr(12'h005, 8'h3c);
		pm_wr(12'h7ff, 8'ha5);
		pm_wr(12'h7f3, 8'h92);
		pm_wr(12'h7e3, 8'hb0);
		fetch_chk(12'h005, 8'h3c);
		fetch_chk(12'h805, 8'h3c);
		fetch_chk(12'hfff, 8'ha5);
		dm_wr(8'hfc, 4'hf);
		dm_wr(8'hfd, 4'hf);
		dm_wr(8'hfe, 4'hf);
		run_op(OP_TAB_LO, 0);
		chk4(acc_load_out, 4'h5);
		chk12(table_pointer_out, 12'hfff);
		run_op(OP_TAB_HI, 0);
		chk4(acc_load_out, 4'ha);
		tick;
		chk12(table_pointer_out, 12'h000);
		dm_chk(8'hfe, 4'h0);
		conv(1'b1, 4'h3, 8'h92);
		conv(1'b0, 4'h3, 8'hb0);
		// Inc then dec lands the low register back on 1
		set_ptr(8'h10);
		dm_st(4'h5, 1'b1, 1'b0);
		chk4(lo_reg_out, 4'h1);
		dm_st(4'hf, 1'b1, 1'b0);
		dm_st(4'hc, 1'b0, 1'b1);
		chk4(lo_reg_out, 4'h1);
		chk4(hi_reg_out, 4'h1);
		dm_chk(8'h10, 4'h5);
		dm_chk(8'h11, 4'hf);
		dm_chk(8'h12, 4'hc);
		set_ptr(8'h0d);
		chk4({1'b0, pin_port_out}, 4'h7);
		chk4({2'b00, pin_bit_out}, 4'h1);
		operand_in = 8'ha5;
		zp_mode_in = 1'b1;
		dm_st(4'h3, 1'b0, 1'b0);
		zp_mode_in = 1'b0;
		dm_chk(8'h05, 4'h3);
		push(OP_CALL, 4'hc, 12'h5a3, 4'h0);
		push(OP_INT, 4'hb, 12'h1b7, 4'h6);
		pop(OP_INTERRUPT_RETURN, 4'ha, 12'h1b7, 4'h6);
		pop(OP_RET, 4'hb, 12'h5a3, 4'h0);
		dm_wr(8'hcc, 4'h1);
		push(OP_CALL, 4'h3, 12'h0de, 4'h0);
		push(OP_CALL, 4'hd, 12'h2c4, 4'h0);
		// A second reset must not disturb the pointer word
		rstn_in = 1'b0;
		tick;
		tick;
		rstn_in = 1'b1;
		tick;
		dm_chk(8'hff, 4'hc);
		report_and_stop;
	end
endmodule
